/* File: logic/jld_pkg.sv */
// Shared encodings, field positions and widths for the jump and load decoder.
package jld_pkg;
    localparam int unsigned JLD_XLEN = 32;
    localparam int unsigned JLD_REGW = 5;
    localparam logic [5:0] JLD_OP_SPECIAL = 6'h00;
    localparam logic [5:0] JLD_OP_DIRECT_BRANCH = 6'h02;
    localparam logic [5:0] JLD_OP_DIRECT_CALL = 6'h03;
    localparam logic [5:0] JLD_OP_LOAD_SBYTE = 6'h20;
    localparam logic [5:0] JLD_OP_LOAD_SHALF = 6'h21;
    localparam logic [5:0] JLD_OP_LOAD_UBYTE = 6'h24;
    localparam logic [5:0] JLD_OP_LOAD_UHALF = 6'h25;
    localparam logic [5:0] JLD_FN_REG_BRANCH = 6'h08;
    localparam logic [5:0] JLD_FN_REG_CALL = 6'h09;
    localparam int unsigned JLD_OP_LSB = 26;
    localparam int unsigned JLD_RA_LSB = 21;
    localparam int unsigned JLD_RB_LSB = 16;
    localparam int unsigned JLD_RD_LSB = 11;
    localparam int unsigned JLD_TGT_W = 26;
    localparam int unsigned JLD_OFS_W = 16;
    localparam int unsigned JLD_FN_W = 6;
    localparam int unsigned JLD_REGION_W = 4;
    localparam logic [4:0] JLD_LINK_REG = 5'h1f;
    localparam logic [31:0] JLD_SLOT_STEP = 32'h0000_0004;
    localparam logic [31:0] JLD_LINK_STEP = 32'h0000_0008;
    localparam logic [1:0] JLD_WORD_ALIGNED = 2'h0;
    localparam logic [31:0] JLD_RESET_WORD = 32'h0000_0000;
    typedef enum logic {JLD_IDLE, JLD_LOAD_WAIT} jld_state_e;
endpackage

/* File: logic/jld_load_format.sv */
// Byte lane selection and extension of loaded partial words.
`timescale 1ns/1ns
module jld_load_format (
    // Loaded word and access shape.
    input wire logic [jld_pkg::JLD_XLEN-1:0] memWord,
    input wire logic [1:0] virtLow,
    input wire logic isHalf,
    input wire logic isSigned,
    input wire logic cpuHighByteFirst,
    // Register file value.
    output logic [jld_pkg::JLD_XLEN-1:0] result
);
    import jld_pkg::*;
    logic [1:0] lane;
    logic [JLD_XLEN-1:0] shifted;

    always_comb begin
        // A halfword keeps its lowest lane bit; only the half selector flips.
        lane = virtLow ^ {cpuHighByteFirst, cpuHighByteFirst & ~isHalf};
        shifted = memWord >> {lane, 3'h0};
        if (isHalf) begin
            result = {{16{isSigned & shifted[15]}}, shifted[15:0]};
        end else begin
            result = {{24{isSigned & shifted[7]}}, shifted[7:0]};
        end
    end
endmodule // jld_load_format

/* File: logic/jld_decode.sv */
// Decode and execution of jumps and partial-word loads for the integer core.
`timescale 1ns/1ns
module jld_decode (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Instruction issue.
    input wire logic instrValid,
    input wire logic [jld_pkg::JLD_XLEN-1:0] instrWord,
    input wire logic [jld_pkg::JLD_XLEN-1:0] instrAddr,
    input wire logic [jld_pkg::JLD_XLEN-1:0] srcAData,
    output logic issueReady,
    // Byte order controls.
    input wire logic cpuHighByteFirst,
    input wire logic swapByteOrderFlag,
    // Fetch redirect.
    output logic redirValid,
    output logic [jld_pkg::JLD_XLEN-1:0] redirTarget,
    output logic redirAddrErr,
    // Register file write.
    output logic rfWrEn,
    output logic [jld_pkg::JLD_REGW-1:0] rfWrAddr,
    output logic [jld_pkg::JLD_XLEN-1:0] rfWrData,
    // Load unit.
    output logic memReq,
    output logic [jld_pkg::JLD_XLEN-1:0] memVAddr,
    output logic [jld_pkg::JLD_XLEN-1:0] memPAddr,
    output logic memHalf,
    input wire logic memRspValid,
    input wire logic [jld_pkg::JLD_XLEN-1:0] memRspData,
    // Data address error.
    output logic addrErrValid,
    output logic [jld_pkg::JLD_XLEN-1:0] addrErrVAddr
);
    import jld_pkg::*;

    typedef struct packed {
        jld_state_e state;
        logic ready;
        logic jmpPend;
        logic [JLD_XLEN-1:0] jmpTarget;
        logic redirValid;
        logic [JLD_XLEN-1:0] redirTarget;
        logic redirAddrErr;
        logic rfWrEn;
        logic rfFromLoad;
        logic [JLD_REGW-1:0] rfWrAddr;
        logic [JLD_XLEN-1:0] rfWrData;
        logic memReq;
        logic [JLD_XLEN-1:0] memVAddr;
        logic [JLD_XLEN-1:0] memPAddr;
        logic memHalf;
        logic loadSigned;
        logic aeValid;
        logic [JLD_XLEN-1:0] aeVAddr;
    } jld_regs_s;

    function automatic logic [JLD_REGW-1:0] regField(input logic [JLD_XLEN-1:0] w,
                                                       input int unsigned lsb);
        regField = w[lsb +: JLD_REGW];
    endfunction

    jld_regs_s st_q;
    jld_regs_s st_d;
    logic accept;
    logic [5:0] opcode;
    logic [5:0] funct;
    logic isSpecial;
    logic isDirect;
    logic isRegJump;
    logic isLoad;
    logic isHalfOp;
    logic [JLD_XLEN-1:0] effAddr;
    logic [JLD_XLEN-1:0] slotAddr;
    logic [JLD_XLEN-1:0] linkAddr;
    logic [JLD_XLEN-1:0] loadResult;

    assign accept = instrValid & st_q.ready;
    assign opcode = instrWord[JLD_OP_LSB +: 6];
    assign funct = instrWord[JLD_FN_W-1:0];
    assign isSpecial = opcode == JLD_OP_SPECIAL;
    assign isDirect = opcode == JLD_OP_DIRECT_BRANCH || opcode == JLD_OP_DIRECT_CALL;
    assign isRegJump = isSpecial && (funct == JLD_FN_REG_BRANCH || funct == JLD_FN_REG_CALL);
    assign isHalfOp = opcode == JLD_OP_LOAD_SHALF || opcode == JLD_OP_LOAD_UHALF;
    assign isLoad = isHalfOp || opcode == JLD_OP_LOAD_SBYTE || opcode == JLD_OP_LOAD_UBYTE;
    assign effAddr = srcAData + {{(JLD_XLEN-JLD_OFS_W){instrWord[JLD_OFS_W-1]}},
                                 instrWord[JLD_OFS_W-1:0]};
    assign slotAddr = instrAddr + JLD_SLOT_STEP;
    assign linkAddr = instrAddr + JLD_LINK_STEP;

    jld_load_format loadFormat (
        .memWord(memRspData),
        .virtLow(st_q.memVAddr[1:0]),
        .isHalf(st_q.memHalf),
        .isSigned(st_q.loadSigned),
        .cpuHighByteFirst(cpuHighByteFirst),
        .result(loadResult)
    );

    always_comb begin
        st_d = st_q;
        st_d.redirValid = 1'b0;
        st_d.rfWrEn = 1'b0;
        st_d.rfFromLoad = 1'b0;
        st_d.memReq = 1'b0;
        st_d.aeValid = 1'b0;
        unique case (st_q.state)
            JLD_IDLE: begin
                if (accept) begin
                    // The slot instruction is taken before the jump lands.
                    if (st_q.jmpPend) begin
                        st_d.jmpPend = 1'b0;
                        st_d.redirValid = 1'b1;
                        st_d.redirTarget = st_q.jmpTarget;
                        // The fault belongs to the target fetch, so it rides the redirect.
                        st_d.redirAddrErr = st_q.jmpTarget[1:0] != JLD_WORD_ALIGNED;
                    end
                    if (isDirect) begin
                        st_d.jmpPend = 1'b1;
                        st_d.jmpTarget = {slotAddr[JLD_XLEN-1 -: JLD_REGION_W],
                                          instrWord[JLD_TGT_W-1:0], 2'h0};
                        if (opcode == JLD_OP_DIRECT_CALL) begin
                            st_d.rfWrEn = 1'b1;
                            st_d.rfWrAddr = JLD_LINK_REG;
                            st_d.rfWrData = linkAddr;
                        end
                    end else if (isRegJump) begin
                        st_d.jmpPend = 1'b1;
                        st_d.jmpTarget = srcAData;
                        if (funct == JLD_FN_REG_CALL) begin
                            // Equal source and destination is left undefined by software contract.
                            st_d.rfWrEn = 1'b1;
                            st_d.rfWrAddr = regField(instrWord, JLD_RD_LSB);
                            st_d.rfWrData = linkAddr;
                        end
                    end else if (isLoad) begin
                        st_d.rfWrAddr = regField(instrWord, JLD_RB_LSB);
                        st_d.memHalf = isHalfOp;
                        st_d.loadSigned = ~opcode[2];
                        st_d.memVAddr = effAddr;
                        if (isHalfOp && effAddr[0]) begin
                            st_d.aeValid = 1'b1;
                            st_d.aeVAddr = effAddr;
                        end else begin
                            st_d.memReq = 1'b1;
                            st_d.memPAddr = {effAddr[JLD_XLEN-1:2], effAddr[1:0] ^
                                {swapByteOrderFlag, swapByteOrderFlag & ~isHalfOp}};
                            st_d.ready = 1'b0;
                            st_d.state = JLD_LOAD_WAIT;
                        end
                    end
                end
            end
            JLD_LOAD_WAIT: begin
                if (memRspValid) begin
                    st_d.rfWrEn = 1'b1;
                    st_d.rfFromLoad = 1'b1;
                    st_d.rfWrData = loadResult;
                    st_d.ready = 1'b1;
                    st_d.state = JLD_IDLE;
                end
            end
        endcase
        if (sys_rst) begin
            st_d = '0;
            st_d.state = JLD_IDLE;
            st_d.ready = 1'b1;
            st_d.rfWrData = JLD_RESET_WORD;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_q <= st_d;
    end

    assign issueReady = st_q.ready;
    assign redirValid = st_q.redirValid;
    assign redirTarget = st_q.redirTarget;
    assign redirAddrErr = st_q.redirAddrErr;
    assign rfWrEn = st_q.rfWrEn;
    assign rfWrAddr = st_q.rfWrAddr;
    assign rfWrData = st_q.rfWrData;
    assign memReq = st_q.memReq;
    assign memVAddr = st_q.memVAddr;
    assign memPAddr = st_q.memPAddr;
    assign memHalf = st_q.memHalf;
    assign addrErrValid = st_q.aeValid;
    assign addrErrVAddr = st_q.aeVAddr;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    jump_delay_a: assert property (accept && isDirect && !st_q.jmpPend |=> !redirValid ##0
        st_q.jmpPend) else $error("Jump redirected without a delay slot.");
    slot_redirect_a: assert property (accept && isDirect && !st_q.jmpPend ##1 accept |=>
        redirValid && redirTarget[1:0] == 2'h0) else $error("Direct jump missed its redirect.");
    call_link_a: assert property (accept && opcode == JLD_OP_DIRECT_CALL |=> rfWrEn &&
        rfWrAddr == JLD_LINK_REG && rfWrData == $past(instrAddr) + JLD_LINK_STEP)
        else $error("Direct call link wrong.");
    reg_link_a: assert property (accept && isSpecial && funct == JLD_FN_REG_CALL |=> rfWrEn &&
        rfWrAddr == $past(instrWord[15:11]) && !addrErrValid && !redirValid)
        else $error("Register call link wrong.");
    reg_target_a: assert property (accept && isRegJump && !st_q.jmpPend ##1 accept |=>
        redirValid && redirTarget == $past(srcAData, 2) &&
        redirAddrErr == ($past(srcAData[1:0], 2) != 2'h0))
        else $error("Register jump target or fault flag wrong.");
    load_addr_a: assert property (memReq |-> memVAddr == $past(srcAData) +
        {{16{$past(instrWord[15])}}, $past(instrWord[15:0])})
        else $error("Load address wrong.");
    half_fault_a: assert property (accept && isHalfOp && effAddr[0] |=> addrErrValid &&
        !memReq && issueReady) else $error("Odd halfword load not faulted.");
    byte_sign_a: assert property (rfWrEn && st_q.rfFromLoad && !memHalf |->
        rfWrData[31:8] == (st_q.loadSigned ? {24{rfWrData[7]}} : 24'h0))
        else $error("Byte load extension wrong.");
    half_sign_a: assert property (rfWrEn && st_q.rfFromLoad && memHalf |->
        rfWrData[31:16] == (st_q.loadSigned ? {16{rfWrData[15]}} : 16'h0))
        else $error("Halfword load extension wrong.");
    phys_lane_a: assert property (memReq |-> memPAddr[0] == (memVAddr[0] ^
        ($past(swapByteOrderFlag) & !memHalf)) && memPAddr[1] == (memVAddr[1] ^
        $past(swapByteOrderFlag))) else $error("Physical lane swap wrong.");
endmodule // jld_decode

/* File: tb/jld_mem_model.sv */
// Behavioural load unit that answers each load request after a short or a long wait.
`timescale 1ns/1ns
module jld_mem_model
    import jld_pkg::*;
#(
    parameter logic [31:0] MEM_WORD = 32'h7a91_f28e
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Request side.
    input wire logic memReq,
    input wire logic slowRsp,
    // Answer side.
    output logic memRspValid = 1'b0,
    output logic [JLD_XLEN-1:0] memRspData = 32'h0
);
    logic [3:0] waitQ = 4'h0;
    logic busyQ = 1'b0;

    // Outside the answer cycle the data inverts every cycle, so a stale capture is caught.
    always @(posedge sys_clk) begin
        memRspValid <= 1'b0;
        memRspData <= ~memRspData;
        if (sys_rst) begin
            busyQ <= 1'b0;
        end else if (memReq) begin
            busyQ <= 1'b1;
            waitQ <= slowRsp ? 4'h5 : 4'h0;
        end else if (busyQ && waitQ == 4'h0) begin
            busyQ <= 1'b0;
            memRspValid <= 1'b1;
            memRspData <= MEM_WORD;
        end else if (busyQ) begin
            waitQ <= waitQ - 4'h1;
        end
    end
endmodule // jld_mem_model

/* File: tb/jump_and_load_decode_tb.sv */
// Self-checking bench for the jump and partial-word load decoder.
`timescale 1ns/1ns
module jump_and_load_decode_tb;
    import jld_pkg::*;
    localparam logic [31:0] MEM_WORD = 32'h7a91_f28e;
    localparam logic [25:0] TGT = 26'h2a5_5a5c;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic instrValid = 1'b0;
    logic [31:0] instrWord = 32'h0;
    logic [31:0] instrAddr = 32'h0;
    logic [31:0] srcAData = 32'h0;
    logic cpuHighByteFirst = 1'b0;
    logic swapByteOrderFlag = 1'b0;
    logic slowRsp = 1'b0;
    logic issueReady, redirValid, redirAddrErr, rfWrEn, memReq, memHalf, memRspValid, addrErrValid;
    logic [4:0] rfWrAddr;
    logic [31:0] redirTarget, rfWrData, memVAddr, memPAddr, memRspData, addrErrVAddr;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    always #50 sys_clk = ~sys_clk;

    jld_decode u_dut (.sys_clk, .sys_rst, .instrValid, .instrWord, .instrAddr, .srcAData,
        .issueReady, .cpuHighByteFirst, .swapByteOrderFlag, .redirValid, .redirTarget,
        .redirAddrErr, .rfWrEn, .rfWrAddr, .rfWrData, .memReq, .memVAddr, .memPAddr, .memHalf,
        .memRspValid, .memRspData, .addrErrValid, .addrErrVAddr);
    jld_mem_model #(.MEM_WORD(MEM_WORD)) u_mem (.sys_clk, .sys_rst, .memReq, .slowRsp,
        .memRspValid, .memRspData);

    // The whole run needs well under a thousand cycles.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // Valid is left high so that a following issue can be taken back to back.
    task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] s);
        int n;
        n = 0;
        instrValid = 1'b1;
        instrWord = w;
        instrAddr = a;
        srcAData = s;
        while (issueReady !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        @(posedge sys_clk);
        #1;
    endtask

    // Jump at a region edge, so the slot address carries into a new top nibble.
    task automatic jump_case(input logic [31:0] w, input logic link, input logic [4:0] lreg,
                             input logic [31:0] src, input logic [31:0] tgt, input logic aerr);
        issue(w, 32'h1fff_fffc, src);
        chkb(rfWrEn, link);
        if (link) begin
            chk({27'h0, rfWrAddr}, {27'h0, lreg});
            chk(rfWrData, 32'h2000_0004);
        end
        chkb(redirValid, 1'b0);
        chkb(addrErrValid, 1'b0);
        issue(32'h0, 32'h2000_0000, 32'hffff_ffff);
        instrValid = 1'b0;
        chkb(redirValid, 1'b1);
        chk(redirTarget, tgt);
        chkb(redirAddrErr, aerr);
        @(posedge sys_clk);
        #1;
        chkb(redirValid, 1'b0);
    endtask

    // Base plus a negative offset that borrows across the low half of the address.
    task automatic load_case(input logic [5:0] op, input logic [1:0] lo, input logic h,
                             input logic s);
        logic [31:0] ea, word, exp;
        logic [1:0] lane;
        logic half, sgn;
        int n;
        half = op[0];
        sgn = !op[2];
        ea = 32'h0001_fff8 + {30'h0, lo};
        lane = half ? (lo ^ {h, 1'b0}) : (lo ^ {h, h});
        cpuHighByteFirst = h;
        swapByteOrderFlag = s;
        slowRsp = lo[0];
        issue({op, 5'd3, 5'd9, 14'h3ffc, lo}, 32'h0000_0400, 32'h0002_0008);
        instrValid = 1'b0;
        if (half && lo[0]) begin
            chkb(addrErrValid, 1'b1);
            chk(addrErrVAddr, ea);
            chkb(memReq, 1'b0);
            chkb(issueReady, 1'b1);
            // Let an edge pass so that the next issue does not reassign valid in this step.
            @(posedge sys_clk);
            #1;
            chkb(addrErrValid, 1'b0);
        end else begin
            chkb(memReq, 1'b1);
            chk(memVAddr, ea);
            chk(memPAddr, ea ^ {30'h0, s, s & !half});
            chkb(memHalf, half);
            chkb(issueReady, 1'b0);
            n = 0;
            while (rfWrEn !== 1'b1 && n < 20) begin
                @(posedge sys_clk);
                #1;
                n++;
            end
            word = MEM_WORD >> (8 * lane);
            exp = half ? {{16{sgn & word[15]}}, word[15:0]} : {{24{sgn & word[7]}}, word[7:0]};
            chk({27'h0, rfWrAddr}, 32'h9);
            chk(rfWrData, exp);
            chkb(issueReady, 1'b1);
        end
    endtask

    initial begin
        logic [5:0] ops [4];
        ops = '{JLD_OP_LOAD_SBYTE, JLD_OP_LOAD_UBYTE, JLD_OP_LOAD_SHALF, JLD_OP_LOAD_UHALF};
        repeat (3) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        chkb(issueReady, 1'b1);
        chkb(rfWrEn, 1'b0);
        jump_case({JLD_OP_DIRECT_BRANCH, TGT}, 1'b0, 5'h0, 32'h0, {4'h2, TGT, 2'h0}, 1'b0);
        jump_case({JLD_OP_DIRECT_CALL, TGT}, 1'b1, 5'h1f, 32'h0, {4'h2, TGT, 2'h0}, 1'b0);
        // Source and destination differ, as software must keep them.
        jump_case({JLD_OP_SPECIAL, 5'd2, 5'd0, 5'd5, 5'd0, JLD_FN_REG_CALL}, 1'b1, 5'h5,
                  32'h0040_1230, 32'h0040_1230, 1'b0);
        jump_case({JLD_OP_SPECIAL, 5'd2, 5'd0, 5'd7, 5'd0, JLD_FN_REG_CALL}, 1'b1, 5'h7,
                  32'h0040_1231, 32'h0040_1231, 1'b1);
        jump_case({JLD_OP_SPECIAL, 5'd2, 15'h0, JLD_FN_REG_BRANCH}, 1'b0, 5'h0,
                  32'h0000_0102, 32'h0000_0102, 1'b1);
        for (int i = 0; i < 16; i++) begin
            load_case(ops[i / 4], 2'(i), 1'(i ^ (i >> 2)), 1'((i >> 1) ^ (i >> 3)));
        end
        end_of_test();
    end
endmodule // jump_and_load_decode_tb
